// >>> rtl/clk_pin_defs.vh
// Named offsets, field positions, reset values and counts for the pin mux.
`ifndef CLK_PIN_DEFS_VH
`define CLK_PIN_DEFS_VH

// Byte offsets in the configuration space.
`define OFS_PCI_OE_BYTE 8'h02
`define OFS_CLKREQ_BYTE 8'h05
`define OFS_STRAP_BYTE 8'h07

// Field positions in the output enable byte.
`define BIT_OE_LEGACY0 0
`define BIT_OE_LEGACY1 1
`define BIT_OE_LEGACY2 2

// Field positions in the clock request configuration byte.
`define BIT_REQ_A_EN 7
`define BIT_REQ_A_SEL 6
`define BIT_REQ_B_EN 5
`define BIT_REQ_B_SEL 4

// Field positions in the strap status byte.
`define BIT_ST_TRUSTED 0
`define BIT_ST_PAIR5 1
`define BIT_ST_DEBUG 2
`define BIT_ST_DONE 3

// Reset values of the writable bytes.
`define RST_PCI_OE_BYTE 8'hFF
`define RST_CLKREQ_BYTE 8'h00

// Read value for an unmapped offset.
`define RD_UNMAPPED 8'h00

// Cycles after reset release before a strap is taken.
`define STRAP_SETTLE 2'h3

`endif

// >>> rtl/strap_latch.v
// One power-up strap sampler with a two-stage synchroniser.
`timescale 1ns/100ps
`include "clk_pin_defs.vh"

module strap_latch (
  input wire ref_clk, // Block clock.
  input wire rstn, // Asynchronous reset, active low.
  input wire pin_in, // Pin level during power-up.
  output reg value_ff, // Captured strap level.
  output reg done_ff // High once the strap has been taken.
);

  reg sync1_ff; // First synchroniser stage.
  reg sync2_ff; // Second synchroniser stage.
  reg [1:0] settle_ff; // Cycles waited since reset release.

  // Brings the pin level into the clock domain.
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
    end
  end

  // Takes the strap once, after the synchroniser has filled, then holds it.
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      settle_ff <= 2'h0;
      value_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (!done_ff) begin
      if (settle_ff == `STRAP_SETTLE) begin
        value_ff <= sync2_ff;
        done_ff <= 1'b1;
      end else begin
        settle_ff <= settle_ff + 2'h1;
      end
    end
  end

endmodule // strap_latch

// >>> rtl/clock_pin_function_select.v
// Function select for the shared legacy clock and clock request pins.
//
// What this block does
// - Pin A powers up as legacy clock 0.
// - Disabled legacy output pin goes high impedance.
// - Byte 5 bit 7 selects pin A function.
// - Byte 5 bit 6 picks pair 0 or 2.
// - Byte 5 bit 5 selects pin B function.
// - Byte 5 bit 4 picks pair 1 or 4.
// - Trusted strap 0 allows, 1 forbids overclocking.
// - After sampling, trusted pin drives legacy clock 2.
// - Pair5 strap selects stop inputs or pair 5.
// - Free-running clock ignores the stop input.
// - Debug strap selects pair 8 or debug pair.
`timescale 1ns/100ps
`include "clk_pin_defs.vh"

module clock_pin_function_select (
  input wire ref_clk, // 25 MHz block clock.
  input wire rstn, // Asynchronous reset, active low.
  input wire [7:0] reg_addr, // Configuration byte offset.
  input wire [7:0] reg_wdata, // Byte to write.
  input wire reg_wr, // One-cycle write strobe.
  output reg [7:0] reg_rdata_ff, // Byte at reg_addr, one cycle later.
  input wire legacy_clk_src, // Legacy clock waveform to forward.
  input wire pin_a_in, // Pin A input level.
  output reg pin_a_out_ff, // Pin A output level.
  output reg pin_a_oe_n_ff, // Pin A drive enable, low drives.
  input wire pin_b_in, // Pin B input level.
  output reg pin_b_out_ff, // Pin B output level.
  output reg pin_b_oe_n_ff, // Pin B drive enable, low drives.
  input wire pin_c_in, // Trusted strap / legacy clock 2 pin input.
  output reg pin_c_out_ff, // Legacy clock 2 output level.
  output reg pin_c_oe_n_ff, // Pin C drive enable, low drives.
  input wire pin_d_in, // Pair5 strap pin input.
  output reg pin_d_oe_n_ff, // Pin D drive enable, low drives.
  input wire pin_e_in, // Debug strap / free-running clock pin input.
  output reg pin_e_out_ff, // Free-running legacy clock level.
  output reg pin_e_oe_n_ff, // Pin E drive enable, low drives.
  input wire legacy_stop_n, // Legacy clock stop input, active low.
  output reg [4:0] pair_run_ff, // Run enables of pairs 0, 1, 2, 4, 5.
  output reg overclock_allowed_ff, // High when overclocking is allowed.
  output reg stop_inputs_active_ff, // High when stop pins are inputs.
  output reg debug_pair_active_ff // High when debug pair replaces pair 8.
);

  reg [7:0] pci_output_enable_byte_ff; // Legacy output enables.
  reg [7:0] clock_request_config_byte_ff; // Request pin configuration.
  reg req_a_s1_ff; // Request A first sync stage.
  reg req_a_s2_ff; // Request A synchronised.
  reg req_b_s1_ff; // Request B first sync stage.
  reg req_b_s2_ff; // Request B synchronised.
  reg stop_s1_ff; // Stop input first sync stage.
  reg stop_s2_ff; // Stop input synchronised.
  reg [7:0] nxt_rdata; // Read mux result.
  reg [4:0] nxt_pair_run; // Next pair run enables.
  wire trusted_mode_strap; // Latched trusted strap.
  wire pair5_select_strap; // Latched pair5 strap.
  wire debug_pair_select_strap; // Latched debug strap.
  wire done_c; // Trusted strap taken.
  wire done_d; // Pair5 strap taken.
  wire done_e; // Debug strap taken.
  wire straps_done; // All straps taken.
  wire request_a_function_enable; // Pin A works as request input.
  wire request_b_function_enable; // Pin B works as request input.
  wire req_a_sel; // Request A governs pair 2 when high.
  wire req_b_sel; // Request B governs pair 4 when high.
  wire legacy_gate; // Stop input lets stoppable clocks run.

  // Strap samplers for the three dual-purpose pins.
  strap_latch u_trusted (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .pin_in(pin_c_in),
    .value_ff(trusted_mode_strap),
    .done_ff(done_c)
  );

  strap_latch u_pair5 (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .pin_in(pin_d_in),
    .value_ff(pair5_select_strap),
    .done_ff(done_d)
  );

  strap_latch u_debug (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .pin_in(pin_e_in),
    .value_ff(debug_pair_select_strap),
    .done_ff(done_e)
  );

  assign straps_done = done_c & done_d & done_e;

  assign request_a_function_enable =
    clock_request_config_byte_ff[`BIT_REQ_A_EN];
  assign req_a_sel = clock_request_config_byte_ff[`BIT_REQ_A_SEL];
  assign request_b_function_enable =
    clock_request_config_byte_ff[`BIT_REQ_B_EN];
  assign req_b_sel = clock_request_config_byte_ff[`BIT_REQ_B_SEL];

  // The stop pins only exist as inputs when the pair5 strap read low.
  assign legacy_gate = pair5_select_strap | stop_s2_ff;

  // Configuration bytes; a pin turned into a request input is released
  // by the drive logic even while its output enable bit stays set.
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pci_output_enable_byte_ff <= `RST_PCI_OE_BYTE;
      clock_request_config_byte_ff <= `RST_CLKREQ_BYTE;
    end else if (reg_wr) begin
      if (reg_addr == `OFS_PCI_OE_BYTE) begin
        pci_output_enable_byte_ff <= reg_wdata;
      end
      if (reg_addr == `OFS_CLKREQ_BYTE) begin
        clock_request_config_byte_ff <= reg_wdata;
      end
    end
  end

  // Read mux; unmapped offsets read as zero.
  always @* begin
    case (reg_addr)
      `OFS_PCI_OE_BYTE: nxt_rdata = pci_output_enable_byte_ff;
      `OFS_CLKREQ_BYTE: nxt_rdata = clock_request_config_byte_ff;
      `OFS_STRAP_BYTE: begin
        nxt_rdata = 8'h00;
        nxt_rdata[`BIT_ST_TRUSTED] = trusted_mode_strap;
        nxt_rdata[`BIT_ST_PAIR5] = pair5_select_strap;
        nxt_rdata[`BIT_ST_DEBUG] = debug_pair_select_strap;
        nxt_rdata[`BIT_ST_DONE] = straps_done;
      end
      default: nxt_rdata = `RD_UNMAPPED;
    endcase
  end

  // Two-stage synchronisers for the pin inputs read by logic.
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      req_a_s1_ff <= 1'b0;
      req_a_s2_ff <= 1'b0;
      req_b_s1_ff <= 1'b0;
      req_b_s2_ff <= 1'b0;
      stop_s1_ff <= 1'b1;
      stop_s2_ff <= 1'b1;
    end else begin
      req_a_s1_ff <= pin_a_in;
      req_a_s2_ff <= req_a_s1_ff;
      req_b_s1_ff <= pin_b_in;
      req_b_s2_ff <= req_b_s1_ff;
      stop_s1_ff <= legacy_stop_n;
      stop_s2_ff <= stop_s1_ff;
    end
  end

  // Pair run enables: order is 0, 1, 2, 4, 5.
  always @* begin
    nxt_pair_run = 5'h1F;
    if (request_a_function_enable && req_a_s2_ff) begin
      if (req_a_sel) begin
        nxt_pair_run[2] = 1'b0;
      end else begin
        nxt_pair_run[0] = 1'b0;
      end
    end
    if (request_b_function_enable && req_b_s2_ff) begin
      if (req_b_sel) begin
        nxt_pair_run[3] = 1'b0;
      end else begin
        nxt_pair_run[1] = 1'b0;
      end
    end
    nxt_pair_run[4] = pair5_select_strap & straps_done;
  end

  // Registered pin drive and status outputs.
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_ff <= 8'h00;
      pin_a_out_ff <= 1'b0;
      pin_a_oe_n_ff <= 1'b1;
      pin_b_out_ff <= 1'b0;
      pin_b_oe_n_ff <= 1'b1;
      pin_c_out_ff <= 1'b0;
      pin_c_oe_n_ff <= 1'b1;
      pin_d_oe_n_ff <= 1'b1;
      pin_e_out_ff <= 1'b0;
      pin_e_oe_n_ff <= 1'b1;
      pair_run_ff <= 5'h00;
      overclock_allowed_ff <= 1'b0;
      stop_inputs_active_ff <= 1'b0;
      debug_pair_active_ff <= 1'b0;
    end else begin
      reg_rdata_ff <= nxt_rdata;
      pin_a_oe_n_ff <= request_a_function_enable |
        ~pci_output_enable_byte_ff[`BIT_OE_LEGACY0];
      pin_b_oe_n_ff <= request_b_function_enable |
        ~pci_output_enable_byte_ff[`BIT_OE_LEGACY1];
      pin_a_out_ff <= legacy_clk_src & legacy_gate;
      pin_b_out_ff <= legacy_clk_src & legacy_gate;
      pin_c_oe_n_ff <= ~(done_c &
        pci_output_enable_byte_ff[`BIT_OE_LEGACY2]);
      pin_c_out_ff <= legacy_clk_src & legacy_gate;
      // The pair5 strap pin stays released; its clock lies outside here.
      pin_d_oe_n_ff <= 1'b1;
      pin_e_oe_n_ff <= ~done_e;
      pin_e_out_ff <= legacy_clk_src;
      pair_run_ff <= straps_done ? nxt_pair_run : 5'h00;
      overclock_allowed_ff <= done_c & ~trusted_mode_strap;
      stop_inputs_active_ff <= done_d & ~pair5_select_strap;
      debug_pair_active_ff <= done_e & debug_pair_select_strap;
    end
  end

endmodule // clock_pin_function_select

// >>> test/pin_far_side.sv
// Far side model: strap resistors and request logic on the shared pins.
`timescale 1ns/100ps
module pin_far_side (
  input wire [4:0] oe_n, // Block drive enables, pins A to E, low drives.
  input wire [4:0] drv, // Levels the block drives.
  input wire [4:0] ext, // Far side levels on released pins.
  output wire [4:0] lvl // Resolved pin levels.
);
  // released pins show the far side
  assign lvl = (oe_n & ext) | (~oe_n & drv);
endmodule // pin_far_side

// >>> test/pin_func_asserts.sv
// Checker watching the pin function select block at its ports.
`timescale 1ns/100ps
module pin_func_asserts (
  input wire ref_clk, // Block clock.
  input wire rstn, // Reset, active low.
  input wire reg_wr, // Write strobe.
  input wire [7:0] reg_addr, // Byte offset.
  input wire [7:0] reg_wdata, // Write data.
  input wire legacy_clk_src, // Legacy clock source.
  input wire legacy_stop_n, // Stop input level, active low.
  input wire pin_a_in, // Pin A level.
  input wire pin_b_in, // Pin B level.
  input wire pin_c_in, // Pin C level.
  input wire pin_d_in, // Pin D level.
  input wire pin_e_in, // Pin E level.
  input wire pin_a_oe_n_ff, // Pin A release.
  input wire pin_c_oe_n_ff, // Pin C release.
  input wire pin_e_out_ff, // Free-running clock.
  input wire pin_a_out_ff, // Stoppable legacy clock on pin A.
  input wire pin_b_out_ff, // Stoppable legacy clock on pin B.
  input wire pin_c_out_ff, // Stoppable legacy clock on pin C.
  input wire [4:0] pair_run_ff, // Pair run enables.
  input wire overclock_allowed_ff, // Trusted strap result.
  input wire stop_inputs_active_ff, // Pair5 strap result.
  input wire debug_pair_active_ff // Debug strap result.
);
  reg [7:0] b2_ff; // Shadow of the output enable byte.
  reg [7:0] b5_ff; // Shadow of the request byte.
  reg [3:0] cnt_ff; // Edges since release, saturating.
  reg [2:0] st_ff; // Strap levels seen while pins are released.
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Mirror writes and note strap levels early after release.
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      b2_ff <= 8'hFF;
      b5_ff <= 8'h00;
      cnt_ff <= 4'h0;
      st_ff <= 3'h0;
    end else begin
      if (reg_wr && reg_addr == 8'h02) b2_ff <= reg_wdata;
      if (reg_wr && reg_addr == 8'h05) b5_ff <= reg_wdata;
      if (cnt_ff != 4'hF) cnt_ff <= cnt_ff + 4'h1;
      if (cnt_ff == 4'h1) st_ff <= {pin_e_in, pin_d_in, pin_c_in};
    end
  end
  // The first edge after release still shows the reset release level.
  a_pin_a_drive: assert property (
    cnt_ff != 4'h0 |-> pin_a_oe_n_ff == $past(b5_ff[7] | ~b2_ff[0]))
    else $error("pin A");
  a_req_a_stop: assert property (
    (b5_ff[7] && !b5_ff[6] && pin_a_in)[*4] |-> !pair_run_ff[0])
    else $error("pair 0 runs");
  a_req_a_resume: assert property (
    (b5_ff[7] && !b5_ff[6] && !pin_a_in && cnt_ff == 4'hF)[*4]
    |-> pair_run_ff[0]) else $error("pair 0 stopped");
  a_req_b_stop: assert property (
    (b5_ff[5] && b5_ff[4] && pin_b_in)[*4] |-> !pair_run_ff[3])
    else $error("pair 4 runs");
  // Stoppable clocks follow the source a cycle late, gated by the stop pin.
  a_legacy_gate: assert property (
    cnt_ff == 4'hF |-> {pin_a_out_ff, pin_b_out_ff, pin_c_out_ff} ==
    {3{$past(legacy_clk_src) &
    (!stop_inputs_active_ff | $past(legacy_stop_n, 3))}})
    else $error("legacy gate");
  a_trusted_map: assert property (
    cnt_ff == 4'hF |-> overclock_allowed_ff == !st_ff[0]) else $error("trust");
  a_pair5_map: assert property (
    cnt_ff == 4'hF |-> stop_inputs_active_ff == !st_ff[1]) else $error("pair5");
  a_debug_map: assert property (
    cnt_ff == 4'hF |-> debug_pair_active_ff == st_ff[2]) else $error("debug");
  a_strap_hold: assert property (
    cnt_ff == 4'hF |-> $stable({overclock_allowed_ff, stop_inputs_active_ff,
    debug_pair_active_ff})) else $error("strap moved");
  a_strap_release: assert property (
    cnt_ff < 4'h4 |-> pin_c_oe_n_ff) else $error("pin C early");
  a_legacy2_drive: assert property (
    cnt_ff == 4'hF |-> pin_c_oe_n_ff == !$past(b2_ff[2])) else $error("pin C");
  a_free_running: assert property (
    cnt_ff == 4'hF |-> pin_e_out_ff == $past(legacy_clk_src))
    else $error("free clock");
endmodule // pin_func_asserts
bind clock_pin_function_select pin_func_asserts i_chk (.*);

// >>> test/tb.sv
// Testbench for the pin function select block.
`timescale 1ns/100ps
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin n_errors++; \
  $display("Error %s expected %h seen %h", nm, e, s); end end
module tb;
  reg ref_clk = 0, rstn = 0, reg_wr = 0, legacy_clk_src = 0; // Drives.
  reg legacy_stop_n = 1; // Stop input.
  reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00; // Register port.
  reg [4:0] ext = 5'h00; // Far side levels, pins E D C B A.
  reg [15:0] rnd = 16'h49DD; // Random source.
  reg [9:0] q[$]; // Expected results, kind and value.
  reg [9:0] ent; // Oldest note.
  reg look = 0; // A result is due this cycle.
  reg [2:0] s; // Strap levels of this run.
  reg [7:0] cfg [5] = '{8'h00, 8'h80, 8'hC0, 8'h20, 8'h30}; // Request modes.
  int pb [5] = '{7, 0, 2, 1, 3}; // Pair bit each mode stops; 7, outside run, for mode 8'h00, which stops none.
  int n_errors = 0, checked = 0, i; // Counters.
  wire [4:0] oe_n, drv, lvl, run; // Pin and pair signals.
  wire [7:0] rdata; // Read data.
  wire oc, stp, dbg; // Strap results.
  assign drv[3] = 1'b0;
  clock_pin_function_select i_dut (.ref_clk(ref_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rdata_ff(rdata), .legacy_clk_src(legacy_clk_src),
    .pin_a_in(lvl[0]), .pin_a_out_ff(drv[0]), .pin_a_oe_n_ff(oe_n[0]),
    .pin_b_in(lvl[1]), .pin_b_out_ff(drv[1]), .pin_b_oe_n_ff(oe_n[1]),
    .pin_c_in(lvl[2]), .pin_c_out_ff(drv[2]), .pin_c_oe_n_ff(oe_n[2]),
    .pin_d_in(lvl[3]), .pin_d_oe_n_ff(oe_n[3]), .pin_e_in(lvl[4]),
    .pin_e_out_ff(drv[4]), .pin_e_oe_n_ff(oe_n[4]),
    .legacy_stop_n(legacy_stop_n), .pair_run_ff(run),
    .overclock_allowed_ff(oc), .stop_inputs_active_ff(stp),
    .debug_pair_active_ff(dbg));
  pin_far_side i_far (.oe_n(oe_n), .drv(drv), .ext(ext), .lvl(lvl));
  // Next value of the shift register.
  function [15:0] lfsr(input [15:0] x);
    lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  initial forever #20 ref_clk = ~ref_clk;
  // Random legacy clock and stop levels.
  always @(posedge ref_clk) begin
    rnd <= lfsr(rnd);
    legacy_clk_src <= rnd[0];
    legacy_stop_n <= rnd[1];
  end
  // Compare each due result with the oldest note.
  always @(negedge ref_clk) if (look) begin
    ent = q.pop_front();
    case (ent[9:8])
      2'h0: `CHK("read data", ent[7:0], rdata)
      2'h1: `CHK("pair run", ent[7:0], ({3'h0, run}))
      2'h2: `CHK("pin release", ent[7:0], ({3'h0, oe_n}))
      default: `CHK("strap status", ent[7:0], ({5'h0, oc, stp, dbg}))
    endcase
  end
  // Note a result due after the next edge.
  task note_exp(input [1:0] k, input [7:0] e);
    @(posedge ref_clk);
    q.push_back({k, e});
    look <= 1;
    @(posedge ref_clk);
    look <= 0;
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge ref_clk);
    reg_wr <= 0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    note_exp(2'h0, e);
  endtask
  // Reset with strap levels on pins C, D and E.
  task power_up(input [2:0] sv);
    rstn <= 0;
    ext <= {sv, 2'h0};
    repeat (5) @(posedge ref_clk);
    rstn <= 1;
    repeat (8) @(posedge ref_clk);
    note_exp(2'h3, {5'h0, ~sv[0], ~sv[1], sv[2]});
    note_exp(2'h2, 8'h08);
    rd(8'h07, {5'h01, sv});
  endtask
  task summarize;
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    summarize;
  end
  initial begin
    s = rnd[2:0];
    power_up(s);
    rd(8'h02, 8'hFF);
    rd(8'h05, 8'h00);
    rd(8'h33, 8'h00);
    ext[3] <= ~s[1];
    wr(8'h07, 8'hFF);
    note_exp(2'h3, {5'h0, ~s[0], ~s[1], s[2]});
    wr(8'h02, 8'hF8);
    note_exp(2'h2, 8'h0F);
    for (i = 0; i < 5; i++) begin
      wr(8'h05, cfg[i]);
      ext[1:0] <= 2'h3;
      repeat (4) @(posedge ref_clk);
      note_exp(2'h1, {3'h0, s[1], 4'hF} & ~(8'h01 << pb[i]));
      ext[1:0] <= 2'h0;
      repeat (4) @(posedge ref_clk);
      note_exp(2'h1, {3'h0, s[1], 4'hF});
    end
    wr(8'h02, 8'hFF);
    note_exp(2'h2, 8'h0A);
    rd(8'h05, 8'h30);
    power_up(~s);
    summarize;
  end
endmodule // tb
